// ---- hw/adcca_map.svh ----
// Purpose: Register offsets, field positions, reset values and timing counts of the converter control block
// Assumes: 32-bit Wishbone data, byte addresses are the printed offsets
`ifndef ADCCA_MAP_SVH
`define ADCCA_MAP_SVH
`define ADCCA_A_STATUS 7'h00
`define ADCCA_A_MASK 7'h04
`define ADCCA_A_MODE 7'h08
`define ADCCA_A_CH0CON 7'h0C
`define ADCCA_A_CH1CON 7'h10
`define ADCCA_A_FILT 7'h18
`define ADCCA_A_CFG 7'h1C
`define ADCCA_A_RES0 7'h20
`define ADCCA_A_RES1 7'h24
`define ADCCA_A_OF0 7'h30
`define ADCCA_A_OF1 7'h34
`define ADCCA_A_OF2 7'h38
`define ADCCA_A_GN0 7'h3C
`define ADCCA_A_GN1 7'h40
`define ADCCA_A_GN2 7'h44
`define ADCCA_A_RCL 7'h48
`define ADCCA_A_RCV 7'h4C
`define ADCCA_A_TH 7'h50
`define ADCCA_A_THC 7'h54
`define ADCCA_A_THV 7'h58
`define ADCCA_A_ACC 7'h5C
`define ADCCA_A_ATH 7'h60
`define ADCCA_RST_MODE 16'h0003
`define ADCCA_RST_FILT 32'h00000007
`define ADCCA_RST_RCL 16'h0001
`define ADCCA_RST_THC 8'h01
`define ADCCA_GAIN_NOMINAL 16'h5555
`define ADCCA_BIT_CAL 15
`define ADCCA_BIT_ERR1 13
`define ADCCA_BIT_ERR0 12
`define ADCCA_BIT_ACC_EN 5
`define ADCCA_BIT_CODE 0
`define ADCCA_STATUS_USED 16'hB07F
`define ADCCA_GAIN_LSB 15
`define ADCCA_OFS_LSB 24
`define ADCCA_SYNC_NORMAL_NS 8000
`define ADCCA_SYNC_LOWPWR_NS 31000
`define ADCCA_CLK_NS 100
`endif

// ---- hw/adcca_pkg.sv ----
// Purpose: Types shared by the converter control block
// Assumes: Nothing beyond the map header
// Notes: Calibration kinds reported by the converter side
package adcca_pkg;
  typedef enum logic [1:0] {ADCCA_CAL_NONE, ADCCA_CAL_GAIN, ADCCA_CAL_OFFSET} adcca_cal_e;
  typedef logic [31:0] adcca_word_t;
endpackage : adcca_pkg

// ---- hw/adcca_ctrl.sv ----
// Purpose: Wishbone register file, calibration capture, accumulator and error flags of the converter
// Assumes: Converter-side inputs are synchronous to clk_sys; samples arrive as one-cycle strobes
// Notes: Every request answered one cycle after it is seen, with ack if mapped, with err if unmapped
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "adcca_map.svh"
module adcca_ctrl #(
  parameter logic [15:0] GAIN0_TRIM = `ADCCA_GAIN_NOMINAL,
  parameter logic [15:0] GAIN1_TRIM = `ADCCA_GAIN_NOMINAL,
  parameter logic [15:0] GAIN2_TRIM = `ADCCA_GAIN_NOMINAL,
  parameter int SYNC_NS = `ADCCA_SYNC_NORMAL_NS
) (
  input wire logic clk_sys, // System clock 10 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [6:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic wb_err_o, // Unmapped address
  input wire logic smp0_stb, // Current sample strobe
  input wire logic [31:0] smp0_dat, // Current sample value
  input wire logic smp0_range_err, // Current under/overrange with sample
  input wire logic smp1_stb, // Volt/temp sample strobe
  input wire logic [31:0] smp1_dat, // Volt/temp sample value
  input wire logic smp1_range_err, // Volt/temp under/overrange with sample
  input wire logic cal_done_stb, // Calibration cycle finished
  input wire logic [1:0] cal_kind, // Calibration kind, adcca_cal_e
  input wire logic cal_chan, // Calibrated channel, 0 current 1 volt/temp
  input wire logic [31:0] cal_dat, // Raw calibration result
  output logic conv_reset, // Reconfiguration pulse to converter
  output logic sync_busy, // Domain synchronisation in progress
  output logic [31:0] ofs_corr0, // Offset correction current
  output logic [31:0] ofs_corr1, // Offset correction voltage
  output logic [31:0] ofs_corr2, // Offset correction temperature
  output logic [15:0] gain_corr0, // Gain correction current
  output logic [15:0] gain_corr1, // Gain correction voltage
  output logic [15:0] gain_corr2, // Gain correction temperature
  output logic [31:0] current_channel_control, // Current channel control
  output logic [31:0] volt_temp_channel_control, // Volt/temp channel control
  output logic [15:0] mode_control, // Mode control
  output logic [31:0] filter_configuration, // Filter configuration
  output logic irq // Status interrupt request; error flags bypass the mask, low bits masked
);
  localparam int SYNC_CYC = (SYNC_NS + `ADCCA_CLK_NS - 1) / `ADCCA_CLK_NS;
  localparam int SYNC_W = $clog2(SYNC_CYC + 1);

  // Refuse sync delays that the window counter cannot serve
  if (SYNC_CYC < 1 || SYNC_CYC > 4096)
  begin : g_bad_sync
    $error("adcca_ctrl: sync delay out of range");
  end

  logic req;
  logic wr;
  logic rd;
  logic [31:0] wmask;
  logic mapped;
  logic [15:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] cfg_r;
  logic [31:0] res0_r;
  logic [31:0] res1_r;
  logic [15:0] rcl_r;
  logic [15:0] rcv_r;
  logic [31:0] th_r;
  logic [7:0] thc_r;
  logic [31:0] acc_r;
  logic [31:0] ath_r;
  logic [31:0] acc_nxt;
  logic [31:0] rd_nxt;
  logic [SYNC_W-1:0] sync_r;
  logic reconf;
  logic cal_clear;
  logic [31:0] cal_word;

  // Bus request decode; one access per handshake
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr = req && wb_we_i && mapped;
  assign rd = req && !wb_we_i && mapped;

  // Byte lane mask from selects
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sel
      assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // Word-aligned offsets only
  always_comb
  begin
    mapped = 1'b0;
    if (wb_adr_i[1:0] == 2'h0)
    begin
      case (wb_adr_i)
        `ADCCA_A_STATUS, `ADCCA_A_MASK, `ADCCA_A_MODE, `ADCCA_A_CH0CON, `ADCCA_A_CH1CON,
        `ADCCA_A_FILT, `ADCCA_A_CFG, `ADCCA_A_RES0, `ADCCA_A_RES1, `ADCCA_A_OF0, `ADCCA_A_OF1,
        `ADCCA_A_OF2, `ADCCA_A_GN0, `ADCCA_A_GN1, `ADCCA_A_GN2, `ADCCA_A_RCL, `ADCCA_A_RCV,
        `ADCCA_A_TH, `ADCCA_A_THC, `ADCCA_A_THV, `ADCCA_A_ACC, `ADCCA_A_ATH: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // Writes that restart the converter
  assign reconf = wr && (wb_adr_i == `ADCCA_A_MODE || wb_adr_i == `ADCCA_A_CH0CON ||
                         wb_adr_i == `ADCCA_A_CH1CON || wb_adr_i == `ADCCA_A_FILT);
  assign cal_clear = wr && (wb_adr_i == `ADCCA_A_MODE || wb_adr_i == `ADCCA_A_FILT ||
                            wb_adr_i == `ADCCA_A_CH0CON);

  // Calibration result placement by kind
  always_comb
  begin
    cal_word = 32'h00000000;
    case (adcca_pkg::adcca_cal_e'(cal_kind))
      adcca_pkg::ADCCA_CAL_GAIN: cal_word[`ADCCA_GAIN_LSB:0] = cal_dat[`ADCCA_GAIN_LSB:0];
      adcca_pkg::ADCCA_CAL_OFFSET: cal_word[`ADCCA_OFS_LSB:0] = cal_dat[`ADCCA_OFS_LSB:0];
      default: cal_word = cal_dat;
    endcase
  end

  // Bus answer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
    end
  end

  // Read mux; reserved status bits read zero
  always_comb
  begin
    rd_nxt = 32'h00000000;
    case (wb_adr_i)
      `ADCCA_A_STATUS: rd_nxt = {16'h0000, status_r & `ADCCA_STATUS_USED};
      `ADCCA_A_MASK: rd_nxt = {24'h000000, mask_r};
      `ADCCA_A_MODE: rd_nxt = {16'h0000, mode_control};
      `ADCCA_A_CH0CON: rd_nxt = current_channel_control;
      `ADCCA_A_CH1CON: rd_nxt = volt_temp_channel_control;
      `ADCCA_A_FILT: rd_nxt = filter_configuration;
      `ADCCA_A_CFG: rd_nxt = {24'h000000, cfg_r};
      `ADCCA_A_RES0: rd_nxt = res0_r;
      `ADCCA_A_RES1: rd_nxt = res1_r;
      `ADCCA_A_OF0: rd_nxt = ofs_corr0;
      `ADCCA_A_OF1: rd_nxt = ofs_corr1;
      `ADCCA_A_OF2: rd_nxt = ofs_corr2;
      `ADCCA_A_GN0: rd_nxt = {16'h0000, gain_corr0};
      `ADCCA_A_GN1: rd_nxt = {16'h0000, gain_corr1};
      `ADCCA_A_GN2: rd_nxt = {16'h0000, gain_corr2};
      `ADCCA_A_RCL: rd_nxt = {16'h0000, rcl_r};
      `ADCCA_A_RCV: rd_nxt = {16'h0000, rcv_r};
      `ADCCA_A_TH: rd_nxt = th_r;
      `ADCCA_A_THC: rd_nxt = {24'h000000, thc_r};
      `ADCCA_A_THV: rd_nxt = 32'h00000000;
      `ADCCA_A_ACC: rd_nxt = acc_r;
      `ADCCA_A_ATH: rd_nxt = ath_r;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      wb_dat_o <= 32'h00000000;
    else if (rd)
      wb_dat_o <= rd_nxt;
  end

  // Control registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_r <= 8'h00;
      mode_control <= `ADCCA_RST_MODE;
      current_channel_control <= 32'h00000000;
      volt_temp_channel_control <= 32'h00000000;
      filter_configuration <= `ADCCA_RST_FILT;
      cfg_r <= 8'h00;
      rcl_r <= `ADCCA_RST_RCL;
      th_r <= 32'h00000000;
      thc_r <= `ADCCA_RST_THC;
      ath_r <= 32'h00000000;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `ADCCA_A_MASK: mask_r <= (mask_r & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
        `ADCCA_A_MODE: mode_control <= (mode_control & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        `ADCCA_A_CH0CON: current_channel_control <= (current_channel_control & ~wmask) | (wb_dat_i & wmask);
        `ADCCA_A_CH1CON: volt_temp_channel_control <= (volt_temp_channel_control & ~wmask) | (wb_dat_i & wmask);
        `ADCCA_A_FILT: filter_configuration <= (filter_configuration & ~wmask) | (wb_dat_i & wmask);
        `ADCCA_A_CFG: cfg_r <= (cfg_r & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
        `ADCCA_A_RCL: rcl_r <= (rcl_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        `ADCCA_A_TH: th_r <= (th_r & ~wmask) | (wb_dat_i & wmask);
        `ADCCA_A_THC: thc_r <= (thc_r & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
        `ADCCA_A_ATH: ath_r <= (ath_r & ~wmask) | (wb_dat_i & wmask);
        default: ;
      endcase
    end
  end

  // Correction registers: offsets signed, gains unsigned with factory trim at reset
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ofs_corr0 <= 32'h00000000;
      ofs_corr1 <= 32'h00000000;
      ofs_corr2 <= 32'h00000000;
      gain_corr0 <= GAIN0_TRIM;
      gain_corr1 <= GAIN1_TRIM;
      gain_corr2 <= GAIN2_TRIM;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `ADCCA_A_OF0: ofs_corr0 <= (ofs_corr0 & ~wmask) | (wb_dat_i & wmask);
        `ADCCA_A_OF1: ofs_corr1 <= (ofs_corr1 & ~wmask) | (wb_dat_i & wmask);
        `ADCCA_A_OF2: ofs_corr2 <= (ofs_corr2 & ~wmask) | (wb_dat_i & wmask);
        `ADCCA_A_GN0: gain_corr0 <= (gain_corr0 & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        `ADCCA_A_GN1: gain_corr1 <= (gain_corr1 & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        `ADCCA_A_GN2: gain_corr2 <= (gain_corr2 & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        default: ;
      endcase
    end
  end

  // Accumulator next value; wraps without a flag, coding picks sign extension
  always_comb
  begin
    if (current_channel_control[`ADCCA_BIT_CODE])
      acc_nxt = acc_r + smp0_dat;
    else
      acc_nxt = 32'($signed(acc_r) + $signed(smp0_dat));
  end

  // Accumulator and result counter; accumulator takes the sample now, result the cycle after
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_r <= 32'h00000000;
      rcv_r <= 16'h0000;
    end
    else if (reconf || !cfg_r[`ADCCA_BIT_ACC_EN])
    begin
      acc_r <= 32'h00000000;
      rcv_r <= 16'h0000;
    end
    else if (smp0_stb)
    begin
      if (rcv_r + 16'h0001 >= rcl_r)
      begin
        acc_r <= 32'h00000000;
        rcv_r <= 16'h0000;
      end
      else
      begin
        acc_r <= acc_nxt;
        rcv_r <= rcv_r + 16'h0001;
      end
    end
  end

  // Result registers; current result lags the accumulator by one cycle
  logic smp0_stb_d;
  logic [31:0] smp0_dat_d;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      smp0_stb_d <= 1'b0;
      smp0_dat_d <= 32'h00000000;
      res0_r <= 32'h00000000;
      res1_r <= 32'h00000000;
    end
    else
    begin
      smp0_stb_d <= smp0_stb;
      smp0_dat_d <= smp0_dat;
      if (cal_done_stb && !cal_chan)
        res0_r <= cal_word;
      else if (smp0_stb_d)
        res0_r <= smp0_dat_d;
      if (cal_done_stb && cal_chan)
        res1_r <= cal_word;
      else if (smp1_stb)
        res1_r <= smp1_dat;
    end
  end

  // Status flags; set wins over clear
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      status_r <= 16'h0000;
    else
    begin
      if (cal_done_stb)
        status_r[`ADCCA_BIT_CAL] <= 1'b1;
      else if (cal_clear)
        status_r[`ADCCA_BIT_CAL] <= 1'b0;
      if (smp1_stb && smp1_range_err)
        status_r[`ADCCA_BIT_ERR1] <= 1'b1;
      else if (rd && wb_adr_i == `ADCCA_A_STATUS)
        status_r[`ADCCA_BIT_ERR1] <= 1'b0;
      if (smp0_stb && smp0_range_err)
        status_r[`ADCCA_BIT_ERR0] <= 1'b1;
      else if (rd && wb_adr_i == `ADCCA_A_STATUS)
        status_r[`ADCCA_BIT_ERR0] <= 1'b0;
    end
  end

  // Interrupt: error flags requested directly, low bits through the mask
  assign irq = status_r[`ADCCA_BIT_ERR1] || status_r[`ADCCA_BIT_ERR0] ||
               |(status_r[7:0] & mask_r);

  // Synchronisation window after each reconfiguration
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sync_r <= '0;
    else if (reconf)
      sync_r <= SYNC_W'(SYNC_CYC);
    else if (sync_r != '0)
      sync_r <= sync_r - SYNC_W'(1);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      conv_reset <= 1'b0;
    else
      conv_reset <= reconf;
  end

  assign sync_busy = (sync_r != '0);
endmodule : adcca_ctrl
`default_nettype wire

// ---- verif/adcca_assertions.sv ----
// Purpose: Port-level checks of the converter control block
// Assumes: Classic Wishbone master that holds each request until it is answered
// Notes: Bound to every adcca_ctrl instance
`timescale 1ns/1ns
`default_nettype none
`include "adcca_map.svh"
module adcca_chk #(
  parameter logic [15:0] GAIN0_TRIM = 16'h5555
) (
  input wire logic clk_sys, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [6:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic wb_ack_o, // Ack
  input wire logic wb_err_o, // Error
  input wire logic smp0_stb, // Current strobe
  input wire logic smp0_range_err, // Current range error
  input wire logic smp1_stb, // Volt/temp strobe
  input wire logic smp1_range_err, // Volt/temp range error
  input wire logic cal_done_stb, // Calibration done
  input wire logic conv_reset, // Reconfiguration pulse
  input wire logic [15:0] mode_control, // Mode register
  input wire logic [15:0] gain_corr0, // Current gain
  input wire logic irq // Interrupt
);
  // Request taken at this edge
  logic take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Bus answers and decode
  property p_answer; take |=> (wb_ack_o || wb_err_o); endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_unmapped; take && wb_adr_i == 7'h14 |=> wb_err_o && !wb_ack_o; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address not refused");
  property p_mode_wr; wb_ack_o && wb_we_i && wb_adr_i == `ADCCA_A_MODE && wb_sel_i == 4'hF |-> mode_control == wb_dat_i[15:0]; endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
  property p_gain_wr; wb_ack_o && wb_we_i && wb_adr_i == `ADCCA_A_GN0 && wb_sel_i == 4'hF |-> gain_corr0 == wb_dat_i[15:0]; endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");
  property p_trim; $rose(nrst) |-> gain_corr0 == GAIN0_TRIM; endproperty
  a_trim: assert property (@(posedge clk_sys) p_trim) else $error("gain not trimmed at reset");
  // Reconfiguration pulse after mode, filter or current control writes
  property p_reconf; take && wb_we_i && (wb_adr_i == `ADCCA_A_MODE || wb_adr_i == `ADCCA_A_FILT || wb_adr_i == `ADCCA_A_CH0CON) |-> ##[1:2] conv_reset; endproperty
  a_reconf: assert property (p_reconf) else $error("no reconfiguration pulse");
  // Error flags and interrupt
  property p_err0; smp0_stb && smp0_range_err |=> irq; endproperty
  a_err0: assert property (p_err0) else $error("current error gave no irq");
  property p_err1; smp1_stb && smp1_range_err |=> irq; endproperty
  a_err1: assert property (p_err1) else $error("volt/temp error gave no irq");
  property p_clr; take && !wb_we_i && wb_adr_i == `ADCCA_A_STATUS && !smp0_stb && !smp1_stb |=> !irq; endproperty
  a_clr: assert property (p_clr) else $error("status read left irq");
  property p_quiet; !irq && smp0_stb && !smp0_range_err && !smp1_stb && !cal_done_stb |=> !irq; endproperty
  a_quiet: assert property (p_quiet) else $error("sample raised irq");
  c_cal: cover property (cal_done_stb);
  c_err: cover property (wb_err_o);
  c_irq: cover property ($rose(irq));
endmodule : adcca_chk
bind adcca_ctrl adcca_chk #(.GAIN0_TRIM(GAIN0_TRIM)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .smp0_stb(smp0_stb),
  .smp0_range_err(smp0_range_err), .smp1_stb(smp1_stb), .smp1_range_err(smp1_range_err),
  .cal_done_stb(cal_done_stb), .conv_reset(conv_reset), .mode_control(mode_control),
  .gain_corr0(gain_corr0), .irq(irq));
`default_nettype wire

// ---- verif/adcca_conv_model.sv ----
// Purpose: Converter side: samples, range errors and calibration results
// Assumes: Driven by bench task calls, synchronous to clk_sys
// Notes: Data lines show inverted values between strobes
`timescale 1ns/1ns
`default_nettype none
module adcca_conv_model (
  input wire logic clk_sys, // System clock
  output logic smp0_stb, // Current strobe
  output logic [31:0] smp0_dat, // Current sample
  output logic smp0_range_err, // Current range error
  output logic smp1_stb, // Volt/temp strobe
  output logic [31:0] smp1_dat, // Volt/temp sample
  output logic smp1_range_err, // Volt/temp range error
  output logic cal_done_stb, // Calibration finished
  output logic [1:0] cal_kind, // Calibration kind
  output logic cal_chan, // Calibrated channel
  output logic [31:0] cal_dat // Raw calibration result
);
  // Quiet lines at time zero
  initial
  begin
    {smp0_stb, smp1_stb, cal_done_stb, cal_kind, cal_chan, smp0_range_err, smp1_range_err} = '0;
    {smp0_dat, smp1_dat, cal_dat} = '0;
  end
  // One sample; range error stands for the band between the two voltage thresholds
  task automatic sample(input logic ch, input logic [31:0] d, input logic e);
    @(posedge clk_sys);
    smp0_stb <= !ch;
    smp1_stb <= ch;
    {smp0_dat, smp1_dat} <= {d, d};
    {smp0_range_err, smp1_range_err} <= {e, e};
    @(posedge clk_sys);
    {smp0_stb, smp1_stb} <= 2'b00;
    {smp0_dat, smp1_dat} <= {~d, ~d};
    {smp0_range_err, smp1_range_err} <= {!e, !e};
  endtask : sample
  // Calibration cycle end with its raw result
  task automatic calib(input logic [1:0] k, input logic ch, input logic [31:0] d);
    @(posedge clk_sys);
    {cal_done_stb, cal_kind, cal_chan, cal_dat} <= {1'b1, k, ch, d};
    @(posedge clk_sys);
    {cal_done_stb, cal_kind, cal_chan, cal_dat} <= {1'b0, 2'b00, !ch, ~d};
  endtask : calib
endmodule : adcca_conv_model
`default_nettype wire

// ---- verif/adcca_tb.sv ----
// Purpose: Self-checking bench of the converter control block
// Assumes: Classic Wishbone register access, converter side from adcca_conv_model
// Notes: Gain trim values are arbitrary, chosen to differ from nominal
`timescale 1ns/1ns
`default_nettype none
`include "adcca_map.svh"
module tb_top;
  localparam logic [15:0] TRIM0 = 16'h1234; // Arbitrary trim
  localparam logic [15:0] TRIM1 = 16'h2345; // Arbitrary trim
  localparam logic [15:0] TRIM2 = 16'h3456; // Arbitrary trim
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [6:0] wb_adr_i = 7'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, smp0_dat, smp1_dat, cal_dat, ofs0, rd;
  logic wb_ack_o, wb_err_o, irq, bad, busy, smp0_stb, smp0_range_err, smp1_stb, smp1_range_err, cal_done_stb, cal_chan;
  logic [1:0] cal_kind;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  logic [6:0] rst_adr [9] = '{`ADCCA_A_STATUS, `ADCCA_A_MASK, `ADCCA_A_MODE, `ADCCA_A_FILT, `ADCCA_A_RCL,
    `ADCCA_A_THC, `ADCCA_A_GN0, `ADCCA_A_GN1, `ADCCA_A_GN2};
  logic [31:0] rst_val [9] = '{32'h0, 32'h0, 32'h3, 32'h7, 32'h1, 32'h1, {16'h0, TRIM0}, {16'h0, TRIM1},
    {16'h0, TRIM2}};
  logic [6:0] rcf_adr [3] = '{`ADCCA_A_MODE, `ADCCA_A_FILT, `ADCCA_A_CH0CON};
  logic [31:0] rcf_val [3] = '{32'h3, 32'h7, 32'h0};
  // Clock
  always #50 clk_sys = ~clk_sys;
  adcca_ctrl #(.GAIN0_TRIM(TRIM0), .GAIN1_TRIM(TRIM1), .GAIN2_TRIM(TRIM2), .SYNC_NS(300)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .smp0_stb(smp0_stb), .smp0_dat(smp0_dat), .smp0_range_err(smp0_range_err),
    .smp1_stb(smp1_stb), .smp1_dat(smp1_dat), .smp1_range_err(smp1_range_err), .cal_done_stb(cal_done_stb),
    .cal_kind(cal_kind), .cal_chan(cal_chan), .cal_dat(cal_dat), .conv_reset(), .sync_busy(busy), .ofs_corr0(ofs0),
    .ofs_corr1(), .ofs_corr2(), .gain_corr0(), .gain_corr1(), .gain_corr2(), .current_channel_control(),
    .volt_temp_channel_control(), .mode_control(), .filter_configuration(), .irq(irq));
  adcca_conv_model u_conv (.clk_sys(clk_sys), .smp0_stb(smp0_stb), .smp0_dat(smp0_dat),
    .smp0_range_err(smp0_range_err), .smp1_stb(smp1_stb), .smp1_dat(smp1_dat), .smp1_range_err(smp1_range_err),
    .cal_done_stb(cal_done_stb), .cal_kind(cal_kind), .cal_chan(cal_chan), .cal_dat(cal_dat));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask : check
  // One classic cycle, held until ack or err
  task automatic bus(input logic we, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hF, d};
    @(posedge clk_sys);
    // Only the hang guard ends a wait that never gets an answer
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
      @(posedge clk_sys);
    rd = wb_dat_o;
    bad = wb_err_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : bus
  task automatic rd_check(input logic [6:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_check
  // Verdict and end of run
  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      final_report();
    end
  end
  // Test sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) rd_check(rst_adr[i], rst_val[i]);
    bus(1'b0, 7'h14, 32'h0);
    check({31'h0, bad}, 32'h1);
    bus(1'b0, 7'h02, 32'h0);
    check({31'h0, bad}, 32'h1);
    bus(1'b1, `ADCCA_A_STATUS, 32'h4F80);
    rd_check(`ADCCA_A_STATUS, 32'h0);
    bus(1'b1, `ADCCA_A_MASK, 32'hFF);
    rd_check(`ADCCA_A_MASK, 32'hFF);
    bus(1'b1, `ADCCA_A_GN1, 32'hFFFF);
    rd_check(`ADCCA_A_GN1, 32'hFFFF);
    bus(1'b1, `ADCCA_A_OF0, 32'h00800000);
    rd_check(`ADCCA_A_OF0, 32'h00800000);
    for (int i = 0; i < 3; i++)
    begin
      u_conv.calib(2'd1, 1'b0, 32'hABCD5A5A);
      rd_check(`ADCCA_A_STATUS, 32'h8000);
      rd_check(`ADCCA_A_RES0, 32'h5A5A);
      bus(1'b1, `ADCCA_A_GN0, {16'h0, rd[15:0]});
      rd_check(`ADCCA_A_GN0, 32'h5A5A);
      bus(1'b1, rcf_adr[i], rcf_val[i]);
      rd_check(`ADCCA_A_STATUS, 32'h0);
    end
    u_conv.calib(2'd2, 1'b1, 32'hFFFFFFFF);
    rd_check(`ADCCA_A_RES1, 32'h01FFFFFF);
    u_conv.calib(2'd1, 1'b1, 32'h9876C3C3);
    rd_check(`ADCCA_A_RES1, 32'hC3C3);
    bus(1'b1, `ADCCA_A_GN2, {16'h0, rd[15:0]});
    rd_check(`ADCCA_A_GN2, 32'hC3C3);
    bus(1'b1, `ADCCA_A_RCL, 32'hFFFF);
    bus(1'b1, `ADCCA_A_CFG, 32'h20);
    u_conv.sample(1'b0, 32'h10, 1'b0);
    rd_check(`ADCCA_A_ACC, 32'h10);
    bus(1'b1, `ADCCA_A_ACC, 32'h5);
    rd_check(`ADCCA_A_ACC, 32'h10);
    u_conv.sample(1'b0, 32'hFFFFFFF0, 1'b0);
    u_conv.sample(1'b0, 32'h7FFFFFFF, 1'b0);
    u_conv.sample(1'b0, 32'h7FFFFFFF, 1'b0);
    rd_check(`ADCCA_A_ACC, 32'hFFFFFFFE);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, `ADCCA_A_CH0CON, 32'h1);
    // Sync window of 300 ns is three clocks from the taking edge
    @(negedge clk_sys);
    check({31'h0, busy}, 32'h1);
    @(negedge clk_sys);
    check({31'h0, busy}, 32'h1);
    @(negedge clk_sys);
    check({31'h0, busy}, 32'h0);
    rd_check(`ADCCA_A_ACC, 32'h0);
    check(ofs0, 32'h00800000);
    u_conv.sample(1'b0, 32'h10, 1'b0);
    rd_check(`ADCCA_A_ACC, 32'h10);
    rd_check(`ADCCA_A_RCV, 32'h1);
    bus(1'b1, `ADCCA_A_RCL, 32'h2);
    u_conv.sample(1'b0, 32'h10, 1'b0);
    rd_check(`ADCCA_A_ACC, 32'h0);
    rd_check(`ADCCA_A_RCV, 32'h0);
    u_conv.sample(1'b0, 32'h10, 1'b0);
    rd_check(`ADCCA_A_ACC, 32'h10);
    bus(1'b1, `ADCCA_A_MASK, 32'h0);
    bus(1'b1, `ADCCA_A_CFG, 32'h0);
    rd_check(`ADCCA_A_ACC, 32'h0);
    for (int c = 0; c < 2; c++)
    begin
      u_conv.sample(c[0], 32'h1, 1'b1);
      @(negedge clk_sys);
      check({31'h0, irq}, 32'h1);
      rd_check(`ADCCA_A_STATUS, 32'h1000 << c);
      rd_check(`ADCCA_A_STATUS, 32'h0);
      check({31'h0, irq}, 32'h0);
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
